//--- core/fsc_defines.vh
// Constants for the flash command host controller
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
`define FSC_CMD_QUERY 8'h98
`define FSC_CMD_READ_ARRAY 8'hFF
`define FSC_CMD_READ_STATUS 8'h70
`define FSC_CMD_CLEAR_STATUS 8'h50
`define FSC_CMD_PROGRAM 8'h40
`define FSC_CMD_ERASE 8'h20
`define FSC_CMD_CONFIRM 8'hD0
`define FSC_CMD_SUSPEND 8'hB0
`define FSC_CMD_RESUME 8'hD0
`define FSC_REG_CTRL 4'h0
`define FSC_REG_ADDR 4'h1
`define FSC_REG_WDATA 4'h2
`define FSC_REG_RDATA 4'h3
`define FSC_REG_STAT 4'h4
`define FSC_OP_READ 3'h0
`define FSC_OP_QUERY 3'h1
`define FSC_OP_STATUS 3'h2
`define FSC_OP_CLEAR 3'h3
`define FSC_OP_PROGRAM 3'h4
`define FSC_OP_ERASE 3'h5
`define FSC_OP_SUSPEND 3'h6
`define FSC_OP_RESUME 3'h7
`define FSC_STAT_READY 7
`define FSC_STAT_ERASE_FAIL 5
`define FSC_STAT_PROG_FAIL 4
`define FSC_STAT_SUPPLY 3
`define FSC_STAT_SUSPENDED 2
`define FSC_STAT_LOCKED 1
`define FSC_STAT_RESET 8'h80
`define FSC_STROBE_NS 200
`define FSC_CLK_NS 100
`define FSC_STROBE_CYC (((`FSC_STROBE_NS) + (`FSC_CLK_NS) - 1) / (`FSC_CLK_NS))
`endif

//--- core/fsc_host.v
// Host controller driving an asynchronous NOR flash through its bus pins
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fsc_defines.vh"
module fsc_host #(
	parameter AW = 22,
	parameter STROBE_CYC = `FSC_STROBE_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [AW-1:0] flash_addr,
	input wire [15:0] flash_dq_i,
	output reg [15:0] flash_dq_o,
	output reg flash_dq_oe,
	output reg chip_select_n,
	output reg output_enable_n,
	output reg write_enable_n,
	output reg reset_powerdown_n
);
	localparam S_IDLE = 3'd0;
	localparam S_SETUP = 3'd1;
	localparam S_PULSE = 3'd2;
	localparam S_GAP = 3'd3;
	localparam S_DONE = 3'd4;

	reg [2:0] state_q;
	reg [7:0] cnt_q;
	reg [1:0] phase_q;
	reg is_read_q;
	reg [15:0] cyc_data_q;
	reg [AW-1:0] addr_q;
	reg [15:0] wdata_q;
	reg [15:0] rdata_q;
	reg [2:0] op_q;
	reg busy_q;
	reg suspended_q;
	reg [15:0] dq_s1_q;
	reg [15:0] dq_s2_q;
	reg aw_got_q;
	reg w_got_q;
	reg [3:0] aw_idx_q;
	reg [31:0] w_data_q;

	// Number of bus cycles each operation needs; program and erase use two writes
	function [1:0] op_cycles;
		input [2:0] op;
		begin
			case (op)
			`FSC_OP_PROGRAM, `FSC_OP_ERASE: op_cycles = 2'd2;
			`FSC_OP_QUERY, `FSC_OP_STATUS, `FSC_OP_READ: op_cycles = 2'd2;
			default: op_cycles = 2'd1;
			endcase
		end
	endfunction

	// Command byte for the first bus cycle of each operation
	function [7:0] op_code;
		input [2:0] op;
		begin
			case (op)
			`FSC_OP_READ: op_code = `FSC_CMD_READ_ARRAY;
			`FSC_OP_QUERY: op_code = `FSC_CMD_QUERY;
			`FSC_OP_STATUS: op_code = `FSC_CMD_READ_STATUS;
			`FSC_OP_CLEAR: op_code = `FSC_CMD_CLEAR_STATUS;
			`FSC_OP_PROGRAM: op_code = `FSC_CMD_PROGRAM;
			`FSC_OP_ERASE: op_code = `FSC_CMD_ERASE;
			`FSC_OP_SUSPEND: op_code = `FSC_CMD_SUSPEND;
			default: op_code = `FSC_CMD_RESUME;
			endcase
		end
	endfunction

	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire do_write = (aw_got_q | aw_hs) & (w_got_q | w_hs) & ~s_axi_bvalid;
	wire [3:0] aw_idx = aw_hs ? s_axi_awaddr[5:2] : aw_idx_q;
	wire [31:0] wd = w_hs ? s_axi_wdata : w_data_q;
	wire start = do_write && (aw_idx == `FSC_REG_CTRL) && (state_q == S_IDLE) && wd[3];
	wire [3:0] rd_idx = s_axi_araddr[5:2];
	wire is_status_rd = (op_q == `FSC_OP_STATUS);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_idx_q <= 4'h0;
			w_data_q <= 32'h0000_0000;
			addr_q <= {AW{1'b0}};
			wdata_q <= 16'hFFFF;
			reset_powerdown_n <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_got_q & ~aw_hs & ~s_axi_bvalid;
			s_axi_wready <= ~w_got_q & ~w_hs & ~s_axi_bvalid;
			if (aw_hs) begin
				aw_got_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr[5:2];
			end
			if (w_hs) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata;
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (aw_idx)
				`FSC_REG_CTRL: begin
					// Holding the pin low while suspended would abort the program
					if (!suspended_q || wd[4])
						reset_powerdown_n <= wd[4];
				end
				`FSC_REG_ADDR: addr_q <= wd[AW-1:0];
				`FSC_REG_WDATA: wdata_q <= wd[15:0];
				default: s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (rd_idx)
				`FSC_REG_CTRL: s_axi_rdata <= {27'h0, reset_powerdown_n, 1'b0, op_q};
				`FSC_REG_ADDR: s_axi_rdata <= {{(32-AW){1'b0}}, addr_q};
				`FSC_REG_WDATA: s_axi_rdata <= {16'h0000, wdata_q};
				`FSC_REG_RDATA: s_axi_rdata <= {16'h0000, rdata_q};
				`FSC_REG_STAT: s_axi_rdata <= {24'h0, 5'h0, suspended_q, busy_q,
						state_q != S_IDLE};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Pin sampling through two stages before use
	always @(posedge aclk) begin
		if (!aresetn) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else begin
			dq_s1_q <= flash_dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// Bus cycle sequencer; every cycle deasserts both strobes so each status
	// poll sees a fresh latch edge; reads stretch two cycles for the synchroniser
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_IDLE;
			cnt_q <= 8'h00;
			phase_q <= 2'd0;
			is_read_q <= 1'b0;
			cyc_data_q <= 16'h0000;
			op_q <= `FSC_OP_READ;
			rdata_q <= 16'h0000;
			busy_q <= 1'b0;
			suspended_q <= 1'b0;
			flash_addr <= {AW{1'b0}};
			flash_dq_o <= 16'h0000;
			flash_dq_oe <= 1'b0;
			chip_select_n <= 1'b1;
			output_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
		end else begin
			case (state_q)
			S_IDLE: begin
				if (start) begin
					op_q <= wd[2:0];
					phase_q <= 2'd0;
					is_read_q <= 1'b0;
					cyc_data_q <= {8'h00, op_code(wd[2:0])};
					flash_addr <= addr_q;
					state_q <= S_SETUP;
				end
			end
			S_SETUP: begin
				chip_select_n <= 1'b0;
				flash_dq_oe <= ~is_read_q;
				flash_dq_o <= cyc_data_q;
				cnt_q <= is_read_q ? STROBE_CYC[7:0] + 8'h02 : STROBE_CYC[7:0];
				state_q <= S_PULSE;
			end
			S_PULSE: begin
				if (is_read_q)
					output_enable_n <= 1'b0;
				else
					write_enable_n <= 1'b0;
				if (cnt_q == 8'h00) begin
					if (is_read_q)
						rdata_q <= is_status_rd ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
					output_enable_n <= 1'b1;
					write_enable_n <= 1'b1;
					state_q <= S_GAP;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			S_GAP: begin
				chip_select_n <= 1'b1;
				flash_dq_oe <= 1'b0;
				phase_q <= phase_q + 2'd1;
				if (phase_q + 2'd1 < op_cycles(op_q)) begin
					// Second cycle: data write, confirm write, or a read
					is_read_q <= (op_q != `FSC_OP_PROGRAM) && (op_q != `FSC_OP_ERASE);
					cyc_data_q <= (op_q == `FSC_OP_ERASE) ? {8'h00, `FSC_CMD_CONFIRM} :
						wdata_q;
					state_q <= S_SETUP;
				end else begin
					state_q <= S_DONE;
				end
			end
			S_DONE: begin
				case (op_q)
				`FSC_OP_PROGRAM, `FSC_OP_ERASE, `FSC_OP_RESUME: begin
					busy_q <= 1'b1;
					suspended_q <= 1'b0;
				end
				`FSC_OP_SUSPEND: suspended_q <= busy_q;
				`FSC_OP_STATUS: begin
					// Poll result: ready ends the operation, whether or not suspension is reported
					if (rdata_q[`FSC_STAT_READY])
						busy_q <= 1'b0;
					if (rdata_q[`FSC_STAT_READY] && busy_q)
						suspended_q <= rdata_q[`FSC_STAT_SUSPENDED];
				end
				default: begin
				end
				endcase
				state_q <= S_IDLE;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

//--- verif/fsc_flash_model.sv
// Behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
module fsc_flash_model (
	input wire [21:0] addr,
	input wire [15:0] dq_o,
	input wire cs_n,
	input wire oe_n,
	input wire we_n,
	input wire rpn,
	input wire [1:0] bad,
	output wire [15:0] dq
);
	logic [7:0] sr = 8'h80;
	logic [7:0] cmd = 8'hFF;
	logic [7:0] c;
	logic [15:0] mem [0:15] = '{default: 16'hFFFF};
	logic [15:0] lat = 16'h0000;
	logic [7:0] fail_m = 8'h00;
	int cnt = 0;
	wire [15:0] val = cmd == 8'hFF ? mem[addr[3:0]] :
		cmd == 8'h98 ? {8'h00, addr[7:0] ^ 8'h5A} : {8'h00, sr};
	always @(negedge rpn) begin
		sr = 8'h80;
		cmd = 8'hFF;
	end
	// Internal timer stands still while suspended
	always #100 if (cnt > 0 && !sr[2]) begin
		cnt--;
		if (cnt == 0) sr = sr | 8'h80 | fail_m;
	end
	always @(posedge we_n) if (!cs_n && rpn) begin
		c = dq_o[7:0];
		if (cmd == 8'h40) begin
			cmd = 8'h70;
			if (bad == 2'b01) sr[3] = 1'b1;
			else if (bad == 2'b10) sr[1] = 1'b1;
			else begin
				mem[addr[3:0]] &= dq_o;
				// Verify failure only shows once the timed sequence ends
				fail_m = (bad == 2'b11) ? 8'h10 : 8'h00;
				sr[7] = 1'b0;
				cnt = 300;
			end
		end else if (cmd == 8'h20) begin
			cmd = 8'h70;
			if (c != 8'hD0) sr[5:4] = 2'b11;
			else if (bad == 2'b01) sr[5:3] = 3'b101;
			else begin
				mem = '{default: 16'hFFFF};
				fail_m = (bad == 2'b11) ? 8'h20 : 8'h00;
				sr[7] = 1'b0;
				cnt = 300;
			end
		end else if ((!sr[7] && c != 8'h70 && c != 8'hB0) ||
			(sr[2] && c inside {8'h40, 8'h20, 8'h50})) begin
		end else begin
			if (c == 8'h50) sr = sr & 8'hC5;
			if (c == 8'hB0 && cnt > 0) sr[2] = 1'b1;
			if (c == 8'hB0) sr[7] = 1'b1;
			if (c == 8'hD0 && sr[2]) sr = sr & 8'h7B;
			if (c != 8'h50) cmd = c;
		end
	end
	always @(negedge cs_n or negedge oe_n) if (!cs_n && !oe_n) lat = val;
	// Released bus shows the inverse so stale data never passes
	assign dq = (!cs_n && !oe_n && rpn) ? lat : ~lat;
endmodule

//--- verif/fsc_host_sva.sv
// Port assertions for the flash host controller
`timescale 1ns/1ps
module fsc_host_sva (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] s_axi_rresp,
	input wire [21:0] flash_addr,
	input wire [15:0] flash_dq_o,
	input wire flash_dq_oe,
	input wire chip_select_n,
	input wire output_enable_n,
	input wire write_enable_n,
	input wire reset_powerdown_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_idle: assert property ($rose(aresetn) |-> chip_select_n && write_enable_n
		&& !flash_dq_oe && !reset_powerdown_n) else $error("bus active after reset");
	a_write_frame: assert property (!write_enable_n |-> !chip_select_n
		&& flash_dq_oe && output_enable_n) else $error("write strobe unframed");
	a_read_frame: assert property (!output_enable_n |-> !chip_select_n
		&& !flash_dq_oe) else $error("read strobe unframed");
	// Pulse widths assume STROBE_CYC of 1; reads add two synchroniser cycles
	a_we_pulse: assert property ($fell(write_enable_n) |=> write_enable_n
		&& !chip_select_n ##1 chip_select_n) else $error("write pulse width");
	a_oe_toggle: assert property ($fell(output_enable_n) |=> !output_enable_n ##1
		!output_enable_n ##1 output_enable_n && !chip_select_n ##1 chip_select_n)
		else $error("read pulse width");
	a_addr_hold: assert property (!chip_select_n && !$past(chip_select_n) |->
		$stable(flash_addr)) else $error("address moved in cycle");
	a_data_hold: assert property (!write_enable_n |-> $stable(flash_dq_o))
		else $error("write data moved");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	c_write: cover property ($fell(write_enable_n));
	c_read: cover property ($fell(output_enable_n));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind fsc_host fsc_host_sva fsc_host_sva_inst (.aclk, .aresetn, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .flash_addr, .flash_dq_o,
	.flash_dq_oe, .chip_select_n, .output_enable_n, .write_enable_n, .reset_powerdown_n);

//--- verif/fsc_host_bench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module fsc_host_bench;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	logic [31:0] awa = 0, wd = 0, ara = 0, rd_v;
	logic [1:0] bad = 0;
	logic [15:0] d, e;
	logic [33:0] exp_q [$], exp_m [$];
	int mismatches = 0, n_checks = 0;
	wire [21:0] fa;
	wire [15:0] dqi, dqo;
	wire oe, csn, oen, wen, rpn, awr, wr_, bv, arr, rv;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	localparam logic [33:0] M = 34'h3_0000_FFFF;
	always #50 aclk = ~aclk;
	fsc_host #(.STROBE_CYC(1)) fsc_host_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrdy), .flash_addr(fa), .flash_dq_i(dqi), .flash_dq_o(dqo),
		.flash_dq_oe(oe), .chip_select_n(csn), .output_enable_n(oen),
		.write_enable_n(wen), .reset_powerdown_n(rpn));
	fsc_flash_model fsc_flash_model_inst (.addr(fa), .dq_o(dqo), .cs_n(csn), .oe_n(oen),
		.we_n(wen), .rpn(rpn), .bad(bad), .dq(dqi));
	task automatic chk(input logic [33:0] s, input logic [33:0] x);
		n_checks++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch rresp_rdata expected %h seen %h", x, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awa <= {24'h0, a};
		wd <= v;
		awv <= 1;
		wv <= 1;
		brdy <= 1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wr_) wv <= 0;
		end while (bv !== 1'b1);
		brdy <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] m, input logic [33:0] x);
		exp_m.push_back(m);
		exp_q.push_back(x);
		@(posedge aclk);
		ara <= {24'h0, a};
		arv <= 1;
		rrdy <= 1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 0;
		end while (rv !== 1'b1);
		rrdy <= 0;
		rd_v = rdat;
	endtask
	task automatic op(input logic [2:0] o, input logic [7:0] a, input logic [15:0] v,
		input logic [33:0] m, input logic [33:0] x);
		wr(8'h04, {24'h0, a});
		wr(8'h08, {16'h0, v});
		wr(8'h00, {27'h0, 2'b11, o});
		do rd(8'h10, 34'h0, 34'h0); while (rd_v[0] !== 1'b0);
		rd(8'h0C, m, x);
	endtask
	// Polls status until the flash reports ready; upper byte must read zero
	task automatic wait_ready;
		do op(2, 0, 0, 34'h3_0000_FF00, 34'h0); while (rd_v[7] !== 1'b1);
	endtask
	always @(posedge aclk) if (rv && rrdy) begin
		chk({rr, rdat} & exp_m[0], exp_q[0]);
		exp_m.pop_front();
		exp_q.pop_front();
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		d = $urandom(32'hBA69);
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		wr(8'h00, 32'h10);
		op(2, 0, 0, M, 34'h80);
		e = 16'hFFFF;
		repeat (2) begin
			d = $urandom;
			e = e & d;
			op(4, 3, d, 0, 0);
			wait_ready;
			op(0, 3, 0, M, {18'h0, e});
		end
		op(1, 8'h25, 0, M, {26'h0, 8'h25 ^ 8'h5A});
		$display("test modes done");
		bad <= 1;
		op(4, 3, 0, 0, 0);
		op(2, 0, 0, M, 34'h88);
		bad <= 2;
		op(4, 3, 0, 0, 0);
		op(2, 0, 0, M, 34'h8A);
		op(3, 0, 0, 0, 0);
		op(2, 0, 0, M, 34'h80);
		bad <= 0;
		op(5, 3, 0, 0, 0);
		wait_ready;
		op(0, 3, 0, M, 34'hFFFF);
		bad <= 1;
		op(5, 3, 0, 0, 0);
		op(2, 0, 0, M, 34'hA8);
		bad <= 0;
		op(3, 0, 0, 0, 0);
		bad <= 3;
		op(4, 3, 16'hFFFF, 0, 0);
		wait_ready;
		op(2, 0, 0, M, 34'h90);
		op(3, 0, 0, 0, 0);
		op(5, 3, 0, 0, 0);
		wait_ready;
		op(2, 0, 0, M, 34'hA0);
		bad <= 0;
		op(3, 0, 0, 0, 0);
		$display("test errors done");
		op(4, 5, 16'h1234, 0, 0);
		op(6, 0, 0, 0, 0);
		op(2, 0, 0, M, 34'h84);
		op(7, 0, 0, 0, 0);
		op(2, 0, 0, 34'h84, 34'h0);
		rd(8'h20, {34{1'b1}}, 34'h2_0000_0000);
		$display("test suspend done");
		print_verdict;
	end
	initial begin
		#8ms;
		mismatches++;
		print_verdict;
	end
endmodule
